// ---- hdl/bio_outputs.sv ----
// Purpose: traffic light, barrier status and ticket interlock indications
// Assumes: state and angle come from logic on CLK; trigger pin is asynchronous
// Notes:   an active output pulls its pin low or closes the relay
`timescale 1ns/100ps
`default_nettype none
`include "bio_consts.svh"
// Contract
// - traffic light goes to one of four outputs by routing setting
// - traffic light inactive below trigger level, active from it to 90 degrees
// - angles measured from horizontal zero, growing while raising
// - zero trigger level makes traffic light active on entering raising
// - traffic light enable, default on; off forces its output inactive
// - active closes or pulls low; inactive leaves open or floating
// - barrier status on/off; off forces its output inactive
// - barrier status routed to any one of four outputs
// - each of seven states sets status active or inactive
// - raising with angle: inactive first, active at or above angle
// - lowering with angle: active first, inactive at or below angle
// - angle choices 5, 10, 15, 20, 80 and 85 degrees
// - raising set on: status active at once on entry
// - lowering set on: status active at once on entry
// - interlock defaults off; off forces its output inactive
// - interlock set by vendor activation, held while up, cleared when closed
// - interlock on: barrier activates on trigger release
// - interlock off: barrier activates on trigger assertion
// - interlock output polarity selectable
module bio_outputs
  import bio_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              RSTN,
  input  wire bio_pkg::bio_state_t BARRIER_STATE,
  input  wire logic [6:0]        BOOM_ANGLE,
  input  wire logic              TRIGGER_PIN_N,
  input  wire logic              TL_ENABLE,
  input  wire bio_pkg::bio_route_t TL_ROUTE,
  input  wire logic [6:0]        TL_LEVEL,
  input  wire logic              BS_ENABLE,
  input  wire bio_pkg::bio_route_t BS_ROUTE,
  input  wire logic [2:0]        BS_OPT_LOWERED,
  input  wire logic [2:0]        BS_OPT_RAISING,
  input  wire logic [2:0]        BS_OPT_PRAISED,
  input  wire logic [2:0]        BS_OPT_RAISED,
  input  wire logic [2:0]        BS_OPT_LOWERING,
  input  wire logic [2:0]        BS_OPT_PLOWERED,
  input  wire logic [2:0]        BS_OPT_UNKNOWN,
  input  wire logic              TI_ENABLE,
  input  wire bio_pkg::bio_route_t TI_ROUTE,
  input  wire logic              TI_POLARITY_OPEN,
  output logic                   BARRIER_ACTIVATE,
  output logic                   TICKET_INTERLOCK,
  output logic                   DRY_CONTACT_OUTPUT,
  output logic                   OPEN_DRAIN_OUT_A_OE,
  output logic                   OPEN_DRAIN_OUT_B_OE,
  output logic                   STATUS_LAMP_OUT_OE
);
  bio_regs_t r_q;
  bio_regs_t r_d;

  function automatic logic [6:0] opt_angle(input logic [2:0] opt);
    logic [6:0] a;
    a = 7'h00;
    unique case (opt)
      `BIO_OPT_5:  a = `BIO_ANG_5;
      `BIO_OPT_10: a = `BIO_ANG_10;
      `BIO_OPT_15: a = `BIO_ANG_15;
      `BIO_OPT_20: a = `BIO_ANG_20;
      `BIO_OPT_80: a = `BIO_ANG_80;
      `BIO_OPT_85: a = `BIO_ANG_85;
      default:     a = 7'h00;
    endcase
    return a;
  endfunction

  logic       angle_ok;
  logic [2:0] opt;
  logic       tl_raw;
  logic       bs_raw;
  logic       ti_drive;
  logic       trig_now;

  always_comb begin
    r_d = r_q;
    angle_ok = (BOOM_ANGLE <= `BIO_ANGLE_MAX);
    // level compare; zero level takes raising entry
    if (TL_LEVEL == 7'h00) begin
      tl_raw = (BARRIER_STATE != BIO_LOWERED) || (BOOM_ANGLE != 7'h00);
    end else begin
      tl_raw = angle_ok && (BOOM_ANGLE >= TL_LEVEL);
    end
    r_d.tl_act = TL_ENABLE && tl_raw;
    opt = `BIO_OPT_OFF;
    unique case (BARRIER_STATE)
      BIO_LOWERED:  opt = BS_OPT_LOWERED;
      BIO_RAISING:  opt = BS_OPT_RAISING;
      BIO_PRAISED:  opt = BS_OPT_PRAISED;
      BIO_RAISED:   opt = BS_OPT_RAISED;
      BIO_LOWERING: opt = BS_OPT_LOWERING;
      BIO_PLOWERED: opt = BS_OPT_PLOWERED;
      default:      opt = BS_OPT_UNKNOWN;
    endcase
    // per-state setting; angle options only for moving states
    bs_raw = (opt != `BIO_OPT_OFF);
    if (opt >= `BIO_OPT_5) begin
      if (BARRIER_STATE == BIO_RAISING) begin
        bs_raw = BOOM_ANGLE >= opt_angle(opt);
      end else if (BARRIER_STATE == BIO_LOWERING) begin
        bs_raw = BOOM_ANGLE > opt_angle(opt);
      end
    end
    // plain on is immediate; enable gate
    r_d.bs_act = BS_ENABLE && bs_raw;
    // three-stage pin sync; change only when last two agree
    r_d.trig_sync = {r_q.trig_sync[1:0], ~TRIGGER_PIN_N};
    trig_now = r_q.trig_stable;
    if (r_q.trig_sync[2] == r_q.trig_sync[1]) begin
      trig_now = r_q.trig_sync[2];
    end
    r_d.trig_stable = trig_now;
    // release edge with interlock, closing edge without
    if (TI_ENABLE) begin
      r_d.activate = r_q.trig_stable && !trig_now;
    end else begin
      r_d.activate = !r_q.trig_stable && trig_now;
    end
    // set on vendor activation, cleared once fully lowered
    if (r_d.activate && TI_ENABLE) begin
      r_d.interlock = 1'b1;
    end else if (BARRIER_STATE == BIO_LOWERED || !TI_ENABLE) begin
      r_d.interlock = 1'b0;
    end
    // off forces inactive; polarity picks the driven level
    ti_drive = TI_ENABLE && (r_d.interlock ^ TI_POLARITY_OPEN);
    // each output takes only functions routed to it
    for (int i = 0; i < 4; i++) begin
      r_d.out_act[i] = (r_d.tl_act && (TL_ROUTE == bio_route_t'(i)))
                    || (r_d.bs_act && (BS_ROUTE == bio_route_t'(i)))
                    || (ti_drive && (TI_ROUTE == bio_route_t'(i)));
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // active closes the relay or pulls the open-drain pin low
  assign DRY_CONTACT_OUTPUT  = r_q.out_act[`BIO_ROUTE_RELAY];
  assign OPEN_DRAIN_OUT_A_OE = r_q.out_act[`BIO_ROUTE_OD_A];
  assign OPEN_DRAIN_OUT_B_OE = r_q.out_act[`BIO_ROUTE_OD_B];
  assign STATUS_LAMP_OUT_OE  = r_q.out_act[`BIO_ROUTE_LAMP];
  assign BARRIER_ACTIVATE    = r_q.activate;
  assign TICKET_INTERLOCK    = r_q.interlock;
endmodule
`default_nettype wire

// ---- hdl/bio_consts.svh ----
// Purpose: constants for the barrier indication outputs
// Assumes: included by bare name
// Notes:   angles in whole degrees, 0 = horizontal
`ifndef BIO_CONSTS_SVH
`define BIO_CONSTS_SVH
`define BIO_ANGLE_MAX      7'h5A
`define BIO_ROUTE_RELAY    2'h0
`define BIO_ROUTE_OD_A     2'h1
`define BIO_ROUTE_OD_B     2'h2
`define BIO_ROUTE_LAMP     2'h3
`define BIO_OPT_OFF        3'h0
`define BIO_OPT_ON         3'h1
`define BIO_OPT_5          3'h2
`define BIO_OPT_10         3'h3
`define BIO_OPT_15         3'h4
`define BIO_OPT_20         3'h5
`define BIO_OPT_80         3'h6
`define BIO_OPT_85         3'h7
`define BIO_ANG_5          7'h05
`define BIO_ANG_10         7'h0A
`define BIO_ANG_15         7'h0F
`define BIO_ANG_20         7'h14
`define BIO_ANG_80         7'h50
`define BIO_ANG_85         7'h55
`endif

// ---- hdl/bio_pkg.sv ----
// Purpose: types for the barrier indication outputs
// Assumes: nothing
// Notes:   state codes match the barrier controller
package bio_pkg;
  typedef enum logic [2:0] {
    BIO_LOWERED   = 3'h0,
    BIO_RAISING   = 3'h1,
    BIO_PRAISED   = 3'h2,
    BIO_RAISED    = 3'h3,
    BIO_LOWERING  = 3'h4,
    BIO_PLOWERED  = 3'h5,
    BIO_UNKNOWN   = 3'h6
  } bio_state_t;

  typedef enum logic [1:0] {
    BIO_R_RELAY = 2'h0,
    BIO_R_OD_A  = 2'h1,
    BIO_R_OD_B  = 2'h2,
    BIO_R_LAMP  = 2'h3
  } bio_route_t;

  typedef struct packed {
    logic [2:0] trig_sync;
    logic       trig_stable;
    logic       activate;
    logic       interlock;
    logic       tl_act;
    logic       bs_act;
    logic [3:0] out_act;
  } bio_regs_t;
endpackage

// ---- sim/bio_outputs_checker.sv ----
// Purpose: port checks for bio_outputs
// Assumes: bound to bio_outputs
// Notes:   outputs lag state and angle by one cycle, the trigger pin by four
`timescale 1ns/100ps
`default_nettype none
module bio_outputs_checker
  import bio_pkg::*;
(
  input wire logic                CLK,
  input wire logic                RSTN,
  input wire logic                TRIGGER_PIN_N,
  input wire logic                TL_ENABLE,
  input wire logic                BS_ENABLE,
  input wire logic                TI_ENABLE,
  input wire bio_pkg::bio_state_t BARRIER_STATE,
  input wire bio_pkg::bio_route_t TL_ROUTE,
  input wire bio_pkg::bio_route_t BS_ROUTE,
  input wire logic [6:0]          BOOM_ANGLE,
  input wire logic [6:0]          TL_LEVEL,
  input wire logic [2:0]          BS_OPT_RAISING,
  input wire logic                BARRIER_ACTIVATE,
  input wire logic                TICKET_INTERLOCK,
  input wire logic                DRY_CONTACT_OUTPUT,
  input wire logic                OPEN_DRAIN_OUT_B_OE,
  input wire logic                STATUS_LAMP_OUT_OE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  AST_ALL_OFF: assert property (!(TL_ENABLE | BS_ENABLE | TI_ENABLE) |=>
    !(DRY_CONTACT_OUTPUT | OPEN_DRAIN_OUT_B_OE | STATUS_LAMP_OUT_OE)) else $error("all off");
  AST_TL_HIGH: assert property (TL_ENABLE && TL_ROUTE == BIO_R_RELAY && TL_LEVEL != 0 &&
    BOOM_ANGLE >= TL_LEVEL && BOOM_ANGLE <= 7'h5A |=> DRY_CONTACT_OUTPUT) else $error("tl");
  AST_TL_ZERO: assert property (TL_ENABLE && TL_LEVEL == 0 && TL_ROUTE == BIO_R_LAMP &&
    BARRIER_STATE == BIO_RAISING |=> STATUS_LAMP_OUT_OE) else $error("tl zero");
  AST_BS_RAISE: assert property (BS_ENABLE && BS_ROUTE == BIO_R_OD_B &&
    BARRIER_STATE == BIO_RAISING && BS_OPT_RAISING == 3'h1 |=> OPEN_DRAIN_OUT_B_OE) else $error("bs");
  AST_ACT_PULSE: assert property (BARRIER_ACTIVATE |=> !BARRIER_ACTIVATE)
    else $error("pulse");
  AST_ACT_FALL: assert property (!TI_ENABLE && $fell(TRIGGER_PIN_N) |-> ##[2:5] BARRIER_ACTIVATE)
    else $error("no activation");
  AST_TI_RISE: assert property (TI_ENABLE && $fell(TRIGGER_PIN_N) |-> !BARRIER_ACTIVATE [*3])
    else $error("early activation");
  AST_TI_HOLD: assert property (TI_ENABLE && TICKET_INTERLOCK && BARRIER_STATE != BIO_LOWERED
    |=> TICKET_INTERLOCK) else $error("interlock dropped");
endmodule
bind bio_outputs bio_outputs_checker chk_u (.*);
`default_nettype wire

// ---- sim/bio_vendor_model.sv ----
// Purpose: ticket vendor on the trigger pin
// Assumes: pin pulled up, low = switch closed
// Notes:   switch held 8 cycles so the synchroniser sees it
`timescale 1ns/100ps
`default_nettype none
module bio_vendor_model (
  input  wire logic clk,
  input  wire logic issue,
  input  wire logic interlock,
  output var logic  pin_n
);
  initial pin_n = 1'b1;
  // closes only for an issued ticket
  always @(posedge clk) begin
    if (issue && !interlock) begin
      #1 pin_n = 1'b0;
      repeat (8) @(posedge clk);
      #1 pin_n = 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
// Purpose: self-checking bench for bio_outputs
// Assumes: inputs driven 1 ns after the edge
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import bio_pkg::*;
  logic CLK, RSTN, TL_ENABLE, BS_ENABLE, TI_ENABLE, TI_POLARITY_OPEN, issue;
  logic BARRIER_ACTIVATE, TICKET_INTERLOCK, DRY_CONTACT_OUTPUT;
  logic OPEN_DRAIN_OUT_A_OE, OPEN_DRAIN_OUT_B_OE, STATUS_LAMP_OUT_OE;
  wire logic TRIGGER_PIN_N;
  bio_state_t BARRIER_STATE;
  bio_route_t TL_ROUTE, BS_ROUTE, TI_ROUTE;
  logic [6:0] BOOM_ANGLE, TL_LEVEL;
  logic [20:0] opts;
  logic [63:0] bits;
  logic [3:0] ev;
  wire logic [2:0] BS_OPT_LOWERED, BS_OPT_RAISING, BS_OPT_PRAISED, BS_OPT_RAISED;
  wire logic [2:0] BS_OPT_LOWERING, BS_OPT_PLOWERED, BS_OPT_UNKNOWN;
  int seed = 37336;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  assign {BS_OPT_UNKNOWN, BS_OPT_PLOWERED, BS_OPT_LOWERING, BS_OPT_RAISED, BS_OPT_PRAISED,
          BS_OPT_RAISING, BS_OPT_LOWERED} = opts;
  bio_outputs dut_u (.*);
  bio_vendor_model vend_u (.clk(CLK), .issue(issue), .interlock(TICKET_INTERLOCK),
                           .pin_n(TRIGGER_PIN_N));
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  task automatic check(logic [3:0] got, logic [3:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // lowering with an angle stays active only above the threshold
  function automatic logic [3:0] model();
    logic [2:0] op;
    int t;
    logic tl, bs;
    op = opts[3*BARRIER_STATE +: 3];
    t = op > 5 ? 80 + 5 * (op - 6) : 5 * (op - 1);
    tl = TL_ENABLE && (TL_LEVEL == 0 ? !(BARRIER_STATE == BIO_LOWERED && BOOM_ANGLE == 0)
                                     : BOOM_ANGLE >= TL_LEVEL);
    bs = op < 2 ? op != 0 : BARRIER_STATE == BIO_RAISING ? BOOM_ANGLE >= t
       : BARRIER_STATE == BIO_LOWERING ? BOOM_ANGLE > t : 1'b1;
    return (4'(tl) << TL_ROUTE) | (4'(bs & BS_ENABLE) << BS_ROUTE);
  endfunction
  task automatic trig(logic ti, int n_exp, logic lvl);
    int n;
    logic p;
    n = 0;
    p = lvl;
    TI_ENABLE = ti;
    issue = 1'b1;
    repeat (30) begin
      @(posedge CLK);
      #1;
      issue = 1'b0;
      if (BARRIER_ACTIVATE === 1'b1) begin
        n++;
        p = TRIGGER_PIN_N;
      end
    end
    check(4'(n), 4'(n_exp));
    check(4'(p), 4'(lvl));
  endtask
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    {RSTN, TL_ENABLE, BS_ENABLE, TI_ENABLE, TI_POLARITY_OPEN, issue} = '0;
    {BOOM_ANGLE, TL_LEVEL, opts} = '0;
    BARRIER_STATE = BIO_LOWERED;
    TL_ROUTE = BIO_R_RELAY;
    BS_ROUTE = BIO_R_RELAY;
    TI_ROUTE = BIO_R_RELAY;
    repeat (5) @(posedge CLK);
    #1 RSTN = 1'b1;
    ev = 4'h0;
    repeat (1500) begin
      @(posedge CLK);
      #1;
      check({STATUS_LAMP_OUT_OE, OPEN_DRAIN_OUT_B_OE, OPEN_DRAIN_OUT_A_OE, DRY_CONTACT_OUTPUT}, ev);
      bits = {$random(seed), $random(seed)};
      BARRIER_STATE = bio_state_t'(bits[63:61] % 3'h7);
      BOOM_ANGLE = 7'(bits[60:54] % 91);
      TL_LEVEL = bits[53] ? 7'h00 : 7'(bits[52:46] % 91);
      {TL_ENABLE, BS_ENABLE, opts} = bits[45:23];
      TL_ROUTE = bio_route_t'(bits[22:21]);
      BS_ROUTE = bio_route_t'(bits[20:19]);
      ev = model();
    end
    $display("random routing test done");
    TL_ENABLE = 1'b0;
    BS_ENABLE = 1'b0;
    BARRIER_STATE = BIO_RAISED;
    trig(1'b0, 1, 1'b0);
    trig(1'b1, 1, 1'b1);
    check(4'(TICKET_INTERLOCK), 4'h1);
    check(4'(DRY_CONTACT_OUTPUT), 4'h1);
    TI_POLARITY_OPEN = 1'b1;
    @(posedge CLK);
    #1 check(4'(DRY_CONTACT_OUTPUT), 4'h0);
    trig(1'b1, 0, 1'b1);
    BARRIER_STATE = BIO_LOWERED;
    repeat (3) @(posedge CLK);
    #1 check(4'(TICKET_INTERLOCK), 4'h0);
    $display("trigger and interlock test done");
    print_verdict();
  end
endmodule
`default_nettype wire
